/* File: design/dcops_top.sv */
`timescale 1ns/1ps
`include "dcops_defs.svh"

// Function
// - remote disabled: ignore digital and analog remote control attempts
// - without remote permission, control location reads as local
// - standby input has normal or inverted level and function
// - off-only action: standby input can only switch output off
// - auto action: standby toggles output only if turned on elsewhere
// - pin 6 shows overtemperature and power fail, each enable separable
// - pin 14 defaults overvoltage; overvoltage, overcurrent, overpower enables ORed
// - pin 15 shows voltage regulation or output on status by selector
// - after overtemperature: stay off, or restore prior state in auto
// - at power-up output always off: reset clears the restore setting before power-up reads it
// - off setting: output stays off after power fail until user
// - auto setting: output returns after power fail if it was on
// - off setting: leaving remote forces output off
// - auto setting: leaving remote keeps output state
// - power fail immediately turns output off
// - configuration writable only while output is off
module dcops_top
	import dcops_pkg::*;
(
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// register port
	input  wire dcops_bus_t   i_bus,
	output logic [7:0]        o_rdata,
	// analog interface and device status
	input  wire logic         i_remote_standby_input,
	input  wire dcops_alarm_t i_alarms,
	input  wire logic         i_constant_voltage_regulation,
	input  wire logic         i_saved_dc_on,
	input  wire logic         i_analog_remote_req,
	// outputs
	output logic              o_dc_enable,
	output logic              o_pin6_alarm,
	output logic              o_pin14_alarm,
	output logic              o_pin15_status,
	output logic              o_remote_active,
	output logic              o_irq
);

	dcops_state_t s_r;
	dcops_state_t s_nxt;
	logic [3:0]   irq_pend;

	//--------------------------------
	// next state
	//--------------------------------
	always_comb
	begin
		logic         wr_cfg;
		logic         wr_am;
		logic         wr_ctrl;
		logic         wr_istat;
		logic         wr_imask;
		logic         rem_ok;
		logic         rem_exit;
		logic         sb_act;
		logic         sb_prev_act;
		logic         sb_edge;
		logic         prot;
		logic [4:0]   am;
		logic [3:0]   ev;
		dcops_alarm_t a;
		wr_cfg = 1'b0;
		wr_am = 1'b0;
		wr_ctrl = 1'b0;
		wr_istat = 1'b0;
		wr_imask = 1'b0;
		rem_ok = 1'b0;
		rem_exit = 1'b0;
		sb_act = 1'b0;
		sb_prev_act = 1'b0;
		sb_edge = 1'b0;
		prot = 1'b0;
		am = 5'h00;
		ev = 4'h0;
		a = s_r.alm_sync2;
		s_nxt = s_r;

		//--------------------------------
		// input synchronisers
		//--------------------------------
		s_nxt.sb_sync = {s_r.sb_sync[0], i_remote_standby_input};
		s_nxt.sb_prev = s_r.sb_sync[1];
		s_nxt.alm_sync1 = i_alarms;
		s_nxt.alm_sync2 = s_r.alm_sync1;
		s_nxt.cv_sync1 = i_constant_voltage_regulation;
		s_nxt.cv_sync2 = s_r.cv_sync1;

		//--------------------------------
		// decode
		//--------------------------------
		rem_ok = s_r.cfg[`DCOPS_CFG_REMOTE_OK];
		wr_cfg = i_bus.wr && (i_bus.addr == `DCOPS_ADDR_CFG) && !s_r.dc_on;
		wr_am = i_bus.wr && (i_bus.addr == `DCOPS_ADDR_ALM_MASK) && !s_r.dc_on;
		wr_ctrl = i_bus.wr && (i_bus.addr == `DCOPS_ADDR_CTRL);
		wr_istat = i_bus.wr && (i_bus.addr == `DCOPS_ADDR_IRQ_STAT);
		wr_imask = i_bus.wr && (i_bus.addr == `DCOPS_ADDR_IRQ_MASK);
		am = i_bus.wdata[4:0];
		prot = a.overvoltage_alarm || a.overcurrent_alarm || a.overpower_alarm;

		//--------------------------------
		// power-up
		//--------------------------------
		// power-up state
		if (!s_r.started)
		begin
			s_nxt.started = 1'b1;
			s_nxt.dc_on = s_r.cfg[`DCOPS_CFG_PWRON_RST] & i_saved_dc_on;
			s_nxt.on_by_other = s_nxt.dc_on;
		end

		//--------------------------------
		// configuration
		//--------------------------------
		if (wr_cfg)
		begin
			s_nxt.cfg = i_bus.wdata;
		end

		if (wr_am && (am[1:0] != 2'b00) && (am[4:2] != 3'b000))
		begin
			s_nxt.alm_mask = am;
		end

		//--------------------------------
		// remote control
		//--------------------------------
		// remote gate
		if (wr_ctrl && i_bus.wdata[`DCOPS_CTRL_REM] && rem_ok)
		begin
			s_nxt.remote = 1'b1;
		end

		if (i_analog_remote_req && rem_ok)
		begin
			s_nxt.remote = 1'b1;
		end

		if (!rem_ok)
		begin
			s_nxt.remote = 1'b0;
		end

		rem_exit = s_r.remote && ((wr_ctrl && i_bus.wdata[`DCOPS_CTRL_LOCAL]) || !rem_ok);
		if (rem_exit)
		begin
			s_nxt.remote = 1'b0;
			if (!s_r.cfg[`DCOPS_CFG_REXIT_AUTO])
			begin
				s_nxt.dc_on = 1'b0;
			end
		end

		//--------------------------------
		// output on and off commands
		//--------------------------------
		if (wr_ctrl && i_bus.wdata[`DCOPS_CTRL_ON] && !s_r.pf_hold && !s_r.ot_hold)
		begin
			s_nxt.dc_on = 1'b1;
			s_nxt.on_by_other = 1'b1;
		end

		if (wr_ctrl && i_bus.wdata[`DCOPS_CTRL_OFF])
		begin
			s_nxt.dc_on = 1'b0;
			s_nxt.on_by_other = 1'b0;
		end

		//--------------------------------
		// standby input
		//--------------------------------
		// polarity
		sb_act = s_r.sb_sync[1] ^ s_r.cfg[`DCOPS_CFG_SB_INV];
		sb_prev_act = s_r.sb_prev ^ s_r.cfg[`DCOPS_CFG_SB_INV];
		sb_edge = s_r.remote && rem_ok && (sb_act != sb_prev_act);
		if (sb_edge)
		begin
			ev[`DCOPS_IRQ_SB] = 1'b1;
			if (sb_act)
			begin
				s_nxt.dc_on = 1'b0;
			end
			else if (s_r.cfg[`DCOPS_CFG_SB_AUTO] && s_r.on_by_other && !s_r.pf_hold && !s_r.ot_hold)
			begin
				s_nxt.dc_on = 1'b1;
			end
		end

		//--------------------------------
		// overtemperature
		//--------------------------------
		// overtemperature recovery
		if (a.ot && !s_r.ot_hold)
		begin
			s_nxt.ot_hold = 1'b1;
			s_nxt.was_on_ot = s_r.dc_on;
			ev[`DCOPS_IRQ_OT] = 1'b1;
		end

		if (s_r.ot_hold && !a.ot)
		begin
			s_nxt.ot_hold = 1'b0;
			s_nxt.dc_on = s_r.cfg[`DCOPS_CFG_OT_AUTO] & s_r.was_on_ot;
		end

		if (s_r.ot_hold && a.ot)
		begin
			s_nxt.dc_on = 1'b0;
		end

		//--------------------------------
		// power fail
		//--------------------------------
		// power fail off
		if (a.pf && !s_r.pf_hold)
		begin
			s_nxt.pf_hold = 1'b1;
			s_nxt.was_on_pf = s_r.dc_on;
			s_nxt.dc_on = 1'b0;
			ev[`DCOPS_IRQ_PF] = 1'b1;
		end

		if (s_r.pf_hold && a.pf)
		begin
			s_nxt.dc_on = 1'b0;
		end

		if (s_r.pf_hold && !a.pf)
		begin
			s_nxt.pf_hold = 1'b0;
			s_nxt.dc_on = s_r.cfg[`DCOPS_CFG_PF_AUTO] & s_r.was_on_pf;
		end

		//--------------------------------
		// protection trips
		//--------------------------------
		if (prot && s_r.dc_on)
		begin
			s_nxt.dc_on = 1'b0;
			ev[`DCOPS_IRQ_PROT] = 1'b1;
		end

		//--------------------------------
		// interrupts
		//--------------------------------
		// set wins over clear
		if (wr_istat)
		begin
			s_nxt.irq_stat = s_r.irq_stat & ~i_bus.wdata[3:0];
		end

		if (wr_imask)
		begin
			s_nxt.irq_mask = i_bus.wdata[3:0];
		end

		s_nxt.irq_stat = s_nxt.irq_stat | ev;

		//--------------------------------
		// analog interface pins
		//--------------------------------
		// pin 6 routing
		s_nxt.pin6 = (a.ot & s_r.alm_mask[`DCOPS_AM_P1_OT]) | (a.pf & s_r.alm_mask[`DCOPS_AM_P1_PF]);

		s_nxt.pin14 = (a.overvoltage_alarm & s_r.alm_mask[`DCOPS_AM_P2_OVP]) | (a.overcurrent_alarm & s_r.alm_mask[`DCOPS_AM_P2_OCP])
			| (a.overpower_alarm & s_r.alm_mask[`DCOPS_AM_P2_OPP]);

		s_nxt.pin15 = s_r.cfg[`DCOPS_CFG_ST_DCSEL] ? s_r.dc_on : s_r.cv_sync2;

		//--------------------------------
		// register read
		//--------------------------------
		s_nxt.rdata = 8'h00;
		if (i_bus.rd)
		begin
			unique case (i_bus.addr)
				`DCOPS_ADDR_CFG:      s_nxt.rdata = s_r.cfg;
				`DCOPS_ADDR_ALM_MASK: s_nxt.rdata = {3'h0, s_r.alm_mask};
				`DCOPS_ADDR_STATUS:   s_nxt.rdata = {3'h0, s_r.pf_hold, s_r.ot_hold, s_r.on_by_other,
					s_r.remote & rem_ok, s_r.dc_on};
				`DCOPS_ADDR_IRQ_STAT: s_nxt.rdata = {4'h0, s_r.irq_stat};
				`DCOPS_ADDR_IRQ_MASK: s_nxt.rdata = {4'h0, s_r.irq_mask};
				default:              s_nxt.rdata = 8'h00;
			endcase
		end
	end

	//--------------------------------
	// state register
	//--------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			s_r <= '0;
			s_r.cfg <= `DCOPS_CFG_RST;
			s_r.alm_mask <= `DCOPS_ALM_MASK_RST;
			s_r.irq_mask <= `DCOPS_IRQ_MASK_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	//--------------------------------
	// pending interrupts per bit
	//--------------------------------
	for (genvar i = 0; i < 4; i++)
	begin : g_irq
		assign irq_pend[i] = s_r.irq_stat[i] & s_r.irq_mask[i];
	end

	//--------------------------------
	// outputs
	//--------------------------------
	assign o_rdata = s_r.rdata;
	assign o_dc_enable = s_r.dc_on;
	assign o_pin6_alarm = s_r.pin6;
	assign o_pin14_alarm = s_r.pin14;
	assign o_pin15_status = s_r.pin15;
	assign o_remote_active = s_r.remote & s_r.cfg[`DCOPS_CFG_REMOTE_OK];
	assign o_irq = |irq_pend;

endmodule // dcops_top

/* File: design/dcops_defs.svh */
`ifndef DCOPS_DEFS_SVH
`define DCOPS_DEFS_SVH

// register offsets
`define DCOPS_ADDR_CFG      4'h0
`define DCOPS_ADDR_ALM_MASK 4'h1
`define DCOPS_ADDR_CTRL     4'h2
`define DCOPS_ADDR_STATUS   4'h3
`define DCOPS_ADDR_IRQ_STAT 4'h4
`define DCOPS_ADDR_IRQ_MASK 4'h5

// config field positions
`define DCOPS_CFG_REMOTE_OK  0
`define DCOPS_CFG_SB_INV     1
`define DCOPS_CFG_SB_AUTO    2
`define DCOPS_CFG_OT_AUTO    3
`define DCOPS_CFG_PWRON_RST  4
`define DCOPS_CFG_PF_AUTO    5
`define DCOPS_CFG_REXIT_AUTO 6
`define DCOPS_CFG_ST_DCSEL   7

// alarm mask positions
`define DCOPS_AM_P1_OT   0
`define DCOPS_AM_P1_PF   1
`define DCOPS_AM_P2_OVP  2
`define DCOPS_AM_P2_OCP  3
`define DCOPS_AM_P2_OPP  4

// control bits
`define DCOPS_CTRL_ON     0
`define DCOPS_CTRL_OFF    1
`define DCOPS_CTRL_REM    2
`define DCOPS_CTRL_LOCAL  3

// irq bits
`define DCOPS_IRQ_PF   0
`define DCOPS_IRQ_OT   1
`define DCOPS_IRQ_PROT 2
`define DCOPS_IRQ_SB   3

// reset values
`define DCOPS_CFG_RST      8'h01
`define DCOPS_ALM_MASK_RST 5'h07
`define DCOPS_IRQ_MASK_RST 4'h0

`endif

/* File: design/dcops_pkg.sv */
package dcops_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dcops_bus_t;

	typedef struct packed {
		logic ot;
		logic pf;
		logic overvoltage_alarm;
		logic overcurrent_alarm;
		logic overpower_alarm;
	} dcops_alarm_t;

	typedef struct packed {
		logic [7:0]   cfg;
		logic [4:0]   alm_mask;
		logic [3:0]   irq_stat;
		logic [3:0]   irq_mask;
		logic         dc_on;
		logic         remote;
		logic         on_by_other;
		logic         was_on_pf;
		logic         was_on_ot;
		logic         pf_hold;
		logic         ot_hold;
		logic         started;
		logic [1:0]   sb_sync;
		logic         sb_prev;
		dcops_alarm_t alm_sync1;
		dcops_alarm_t alm_sync2;
		logic         cv_sync1;
		logic         cv_sync2;
		logic [7:0]   rdata;
		logic         pin6;
		logic         pin14;
		logic         pin15;
	} dcops_state_t;

endpackage

/* File: sim/dcops_far_end.sv */
`timescale 1ns/1ps
module dcops_far_end
	import dcops_pkg::*;
(
	// clock
	input  wire logic         i_clk,
	// levels asked for by the bench
	input  wire logic         i_sb,
	input  wire dcops_alarm_t i_alm,
	input  wire logic         i_cv,
	// analog interface lines
	output logic              o_sb,
	output dcops_alarm_t      o_alm,
	output logic              o_cv
);
	always_ff @(posedge i_clk)
	begin
		o_sb  <= i_sb;
		o_alm <= i_alm;
		o_cv  <= i_cv;
	end
endmodule // dcops_far_end

/* File: sim/dcops_top_sva.sv */
`timescale 1ns/1ps
module dcops_top_sva
	import dcops_pkg::*;
(
	input wire logic         i_clk,
	input wire logic         i_rst_n,
	input wire dcops_bus_t   i_bus,
	input wire dcops_alarm_t i_alarms,
	input wire logic [7:0]   o_rdata,
	input wire logic         o_dc_enable,
	input wire logic         o_pin6_alarm,
	input wire logic         o_pin14_alarm,
	input wire logic         o_remote_active,
	input wire logic         o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence pf_held; i_alarms.pf[*4]; endsequence
	sequence ot_held; i_alarms.ot[*4]; endsequence
	p6_quiet_a: assert property ((!i_alarms.ot && !i_alarms.pf)[*4] |=> !o_pin6_alarm)
		else $error("pin6 alarm without cause");
	p14_quiet_a: assert property ((!i_alarms.overvoltage_alarm && !i_alarms.overcurrent_alarm && !i_alarms.overpower_alarm)[*4] |=> !o_pin14_alarm)
		else $error("pin14 alarm without cause");
	pf_off_a: assert property (pf_held |=> !o_dc_enable)
		else $error("output on during power fail");
	ot_off_a: assert property (ot_held |=> !o_dc_enable)
		else $error("output on during overtemperature");
	pwr_up_a: assert property ($rose(i_rst_n) |-> !o_dc_enable ##1 !o_dc_enable)
		else $error("output on after power-up");
	local_up_a: assert property ($rose(i_rst_n) |-> !o_remote_active && !o_irq)
		else $error("remote or irq after reset");
	rd_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
		else $error("read data without read");
	rd_unmap_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) > 4'h5 |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // dcops_top_sva

bind dcops_top dcops_top_sva dcops_top_sva_i (.i_clk, .i_rst_n, .i_bus, .i_alarms, .o_rdata, .o_dc_enable,
	.o_pin6_alarm, .o_pin14_alarm, .o_remote_active, .o_irq);

/* File: sim/dcops_top_test.sv */
`timescale 1ns/1ps
module dcops_top_test;
	import dcops_pkg::*;
	logic         clk = 1'b0, rst_n = 1'b0, sb = 1'b0, cv = 1'b0, areq = 1'b0, sb_w, cv_w, dc, p6, p14, p15, rem, irq;
	dcops_bus_t   bus = '0;
	dcops_alarm_t alm = '0, alm_w;
	logic [7:0]   rdata;
	int           n_fail = 0, total_checks = 0;
	always #12.5 clk = ~clk;
	dcops_far_end dcops_far_end_i (.i_clk(clk), .i_sb(sb), .i_alm(alm), .i_cv(cv), .o_sb(sb_w), .o_alm(alm_w),
		.o_cv(cv_w));
	dcops_top dcops_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata), .i_remote_standby_input(sb_w),
		.i_alarms(alm_w), .i_constant_voltage_regulation(cv_w), .i_saved_dc_on(1'b0), .i_analog_remote_req(areq),
		.o_dc_enable(dc), .o_pin6_alarm(p6), .o_pin14_alarm(p14), .o_pin15_status(p15), .o_remote_active(rem),
		.o_irq(irq));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic stop_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_pins;
		rd(4'h1, 8'h07);
		@(posedge clk) alm.ot <= 1'b1;
		cyc(6);
		chkb(p6, 1'b1);
		@(posedge clk) alm <= '{overcurrent_alarm: 1'b1, default: 1'b0};
		cyc(6);
		chkb(p14, 1'b0);
		wr(4'h1, 8'h00);
		wr(4'h1, 8'h1C);
		rd(4'h1, 8'h07);
		wr(4'h1, 8'h09);
		cyc(4);
		chkb(p14, 1'b1);
		@(posedge clk) alm <= '0;
		wr(4'h1, 8'h07);
		@(posedge clk) cv <= 1'b1;
		cyc(6);
		chkb(p15, 1'b1);
		wr(4'h0, 8'h81);
		cyc(4);
		chkb(p15, 1'b0);
		$display("pins done");
	endtask
	task automatic t_remote(input logic [7:0] c, input logic on_exp);
		@(posedge clk) sb <= c[1];
		cyc(4);
		wr(4'h0, c);
		wr(4'h2, 8'h04);
		wr(4'h2, 8'h01);
		cyc(4);
		chkb(dc, 1'b1);
		@(posedge clk) sb <= ~c[1];
		cyc(8);
		chkb(dc, 1'b0);
		@(posedge clk) sb <= c[1];
		cyc(8);
		chkb(dc, on_exp);
		wr(4'h2, 8'h01);
		wr(4'h0, 8'h00);
		rd(4'h0, c);
		wr(4'h2, 8'h08);
		cyc(4);
		chkb(dc, c[6]);
		wr(4'h2, 8'h02);
		$display("remote done");
	endtask
	task automatic t_alarm(input logic [7:0] c, input int k, input logic on_exp);
		wr(4'h0, c);
		wr(4'h2, 8'h04);
		wr(4'h2, 8'h01);
		cyc(4);
		@(posedge clk) alm[4-k] <= 1'b1;
		cyc(6);
		chkb(dc, 1'b0);
		@(posedge clk) alm <= '0;
		cyc(8);
		chkb(dc, on_exp);
		wr(4'h2, 8'h02);
		wr(4'h2, 8'h08);
		$display("alarm done");
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		chkb(dc, 1'b0);
		rd(4'h0, 8'h01);
		rd(4'h9, 8'h00);
		t_pins();
		t_remote(8'h81, 1'b0);
		t_remote(8'h47, 1'b1);
		t_remote(8'h45, 1'b1);
		chkb(irq, 1'b0);
		wr(4'h5, 8'h08);
		cyc(1);
		chkb(irq, 1'b1);
		wr(4'h4, 8'h0F);
		cyc(1);
		chkb(irq, 1'b0);
		t_alarm(8'h01, 1, 1'b0);
		t_alarm(8'h21, 1, 1'b1);
		t_alarm(8'h09, 0, 1'b1);
		wr(4'h0, 8'h00);
		@(posedge clk) areq <= 1'b1;
		wr(4'h2, 8'h04);
		cyc(3);
		chkb(rem, 1'b0);
		rd(4'h3, 8'h00);
		stop_test();
	end
endmodule // dcops_top_test
